// [hw/urxs_pkg.sv]
// Package for the serial receive status, break and baud block.
// Assumes one 100 MHz clock and a plain strobe register port.
// Functional notes
// RULE1: A stop position sampled low sets the frame error flag, status bit 2.
// RULE2: With two stop bits both must be high, or the frame error flag is set.
// RULE3: The frame error flag is read-only, kept with each word and cleared by reset.
// RULE4: A wrong parity sets the parity error flag, status bit 3, only in odd or even mode.
// RULE5: The parity error flag is read-only, kept with each word and cleared by reset.
// RULE6: The idle flag, status bit 4, is 0 from start detection to stop completion, else 1.
// RULE7: Bit times per character follow mode bits 2:1 (parity/data) and mode bit 0 (stops).
// RULE8: A long break ends after the set character length with zeros, data available, frame error, interrupt, idle.
// RULE9: After a break the receiver waits for a high line before looking for a start bit.
// RULE10: During break waiting the idle flag reads high.
// RULE11: With address detect, status bit 5, a 9-bit word with ninth bit 1 is an address.
// RULE12: In address detect the interrupt select is ignored; each ninth-bit word interrupts.
// RULE13: Loopback feeds the transmit output to the receiver, cuts the pin, keeps the transmit pin.
// RULE14: Software sets the mode, then loopback, then enables transmission.
// RULE15: The 16-bit divisor is read/write and baud is clock over 16 times divisor plus one.
// RULE16: Every divisor 0 through 65535 is accepted; 0 gives clock over 16.
// RULE17: A tick at 16 times baud times every bit as sixteen ticks.
package urxs_pkg;
	localparam int AW = 3;
	localparam int DW = 16;
	// Register offsets
	localparam logic [AW-1:0] OFS_MODE  = 3'h0;
	localparam logic [AW-1:0] OFS_STAT  = 3'h1;
	localparam logic [AW-1:0] OFS_DATA  = 3'h2;
	localparam logic [AW-1:0] OFS_BRG   = 3'h3;
	localparam logic [AW-1:0] OFS_INTST = 3'h4;
	localparam logic [AW-1:0] OFS_INTMK = 3'h5;
	// Mode register fields
	localparam int MODE_STOP  = 0;
	localparam int MODE_PDLO  = 1;
	localparam int MODE_LPBK  = 3;
	// Status register fields
	localparam int STAT_AVAIL = 0;
	localparam int STAT_FRAME_ERROR_FLAG  = 2;
	localparam int STAT_PARITY_ERROR_FLAG  = 3;
	localparam int STAT_IDLE  = 4;
	localparam int STAT_ADDRESS_DETECT_ENABLE = 5;
	localparam int STAT_ISEL  = 6;
	// Interrupt event bits
	localparam int NEV     = 3;
	localparam int EV_RX   = 0;
	localparam int EV_FRAME_ERROR_FLAG = 1;
	localparam int EV_PARITY_ERROR_FLAG = 2;
	// Parity/data select encodings
	localparam logic [1:0] PD_8N = 2'h0;
	localparam logic [1:0] PD_8E = 2'h1;
	localparam logic [1:0] PD_8O = 2'h2;
	localparam logic [1:0] PD_9N = 2'h3;
	// Bit timing in ticks and last data bit index
	localparam logic [3:0] TICK_MID  = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] BITS_8    = 4'h7;
	localparam logic [3:0] BITS_9    = 4'h8;
	// Reset values
	localparam logic [DW-1:0] BRG_RST = 16'h0000;
	localparam logic [NEV-1:0] EV_RST = 3'h0;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP1, ST_STOP2, ST_BRK} urxs_st_t;
	// One buffered character with its error flags
	typedef struct packed {
		logic [8:0] data;
		logic       frame_error_flag;
		logic       parity_error_flag;
	} urxs_word_t;
	// Register port request
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} urxs_req_t;
endpackage : urxs_pkg

// [hw/urxs_baud.sv]
// Baud tick divider: one enable pulse every divisor plus one clocks.
// Assumes the divisor comes from a register on the same clock.
module urxs_baud (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic [15:0] divisor_i,
	output logic             tick_o
);
	import urxs_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
	} urxs_bst_t;

	urxs_bst_t q_ff;
	urxs_bst_t nxt_q;

	// Compare with >= so a divisor lowered mid-count cannot wrap
	always_comb
	begin
		nxt_q  = q_ff;
		tick_o = (q_ff.cnt >= divisor_i);             // RULE15
		if (tick_o)
			nxt_q.cnt = 16'h0000;                     // RULE16
		else
			nxt_q.cnt = q_ff.cnt + 16'h0001;
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
			q_ff <= '0;
		else
			q_ff <= nxt_q;
	end
endmodule : urxs_baud

// [hw/urxs_top.sv]
// Serial receiver with status flags, break handling, address detect,
// loopback and a 16x baud tick. Assumes a transmitter on the same clock
// drives tx_data_i and that the receive pin is asynchronous.
module urxs_top (
	input  wire logic            mclk_i,
	input  wire logic            rstn_i,
	input  wire logic [2:0]      reg_addr_i,
	input  wire logic [15:0]     reg_wdata_i,
	input  wire logic            reg_wr_i,
	input  wire logic            reg_rd_i,
	output logic      [15:0]     reg_rdata_o,
	input  wire logic            serial_receive_pin_i,
	input  wire logic            tx_data_i,
	output logic                 serial_transmit_pin_o,
	output logic                 receiver_idle_o,
	output logic                 irq_o
);
	import urxs_pkg::*;

	typedef struct packed {
		logic [1:0]      sync;
		logic            tx;
		urxs_st_t        st;
		logic [3:0]      tcnt;
		logic [3:0]      bcnt;
		logic [8:0]      shreg;
		logic            par_bad;
		logic            fr_bad;
		logic            stop2;
		logic [1:0]      parity_data_select;
		logic            lpbk;
		logic            address_detect_enable;
		logic            isel;
		logic [15:0]     brg;
		urxs_word_t      rbuf;
		logic            avail;
		logic [NEV-1:0]  ev_st;
		logic [NEV-1:0]  ev_mask;
		logic [15:0]     rdata;
	} urxs_state_t;

	urxs_state_t    q_ff;
	urxs_state_t    nxt_q;
	urxs_req_t      req;
	logic           tick;
	logic           rx_line;
	logic           samp;
	logic           finish;
	logic           store;
	logic           is_break;
	logic           addr9;
	logic           fr_now;
	logic [NEV-1:0] ev_set;
	logic [3:0]     last_bit;

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

	urxs_baud u_baud (
		.mclk_i    (mclk_i),
		.rstn_i    (rstn_i),
		.divisor_i (q_ff.brg),
		.tick_o    (tick)
	);

	// Loopback swaps the synchronised pin for the registered transmit bit
	assign rx_line = q_ff.lpbk ? q_ff.tx : q_ff.sync[1];                // RULE13
	assign serial_transmit_pin_o = q_ff.tx;                             // RULE13
	assign receiver_idle_o = (q_ff.st == ST_IDLE) || (q_ff.st == ST_BRK); // RULE6 RULE10
	assign irq_o = |(q_ff.ev_st & q_ff.ev_mask);
	assign reg_rdata_o = q_ff.rdata;

	// Receive state machine, register port and event logic
	always_comb
	begin
		nxt_q    = q_ff;
		nxt_q.sync = {q_ff.sync[0], serial_receive_pin_i};
		nxt_q.tx = tx_data_i;
		last_bit = (q_ff.parity_data_select == PD_9N) ? BITS_9 : BITS_8;             // RULE7
		addr9    = q_ff.address_detect_enable && (q_ff.parity_data_select == PD_9N);                 // RULE11
		samp     = tick && (q_ff.tcnt == TICK_LAST);                    // RULE17
		finish   = 1'b0;
		fr_now   = q_ff.fr_bad | ~rx_line;
		ev_set   = '0;
		if (tick && q_ff.st != ST_IDLE && q_ff.st != ST_BRK)
			nxt_q.tcnt = q_ff.tcnt + 4'h1;                              // RULE17
		case (q_ff.st)
			ST_IDLE:
			begin
				if (!rx_line)
				begin
					nxt_q.st      = ST_START;
					nxt_q.tcnt    = 4'h0;
					nxt_q.shreg   = '0;
					nxt_q.fr_bad  = 1'b0;
					nxt_q.par_bad = 1'b0;
				end
			end
			ST_START:
			begin
				// A glitch shorter than half a bit is not a start
				if (tick && q_ff.tcnt == TICK_MID)
				begin
					nxt_q.tcnt = 4'h0;
					nxt_q.bcnt = 4'h0;
					nxt_q.st   = rx_line ? ST_IDLE : ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (samp)
				begin
					nxt_q.shreg[q_ff.bcnt] = rx_line;
					nxt_q.bcnt = q_ff.bcnt + 4'h1;
					if (q_ff.bcnt == last_bit)                          // RULE7
						nxt_q.st = (q_ff.parity_data_select == PD_8E || q_ff.parity_data_select == PD_8O) ? ST_PAR : ST_STOP1;
				end
			end
			ST_PAR:
			begin
				if (samp)
				begin
					// Even wants an even count of ones, odd an odd count
					nxt_q.par_bad = (^{q_ff.shreg[7:0], rx_line}) ^ (q_ff.parity_data_select == PD_8O); // RULE4
					nxt_q.st = ST_STOP1;
				end
			end
			ST_STOP1:
			begin
				if (samp)
				begin
					nxt_q.fr_bad = fr_now;                              // RULE1
					if (q_ff.stop2)
						nxt_q.st = ST_STOP2;                            // RULE2 RULE7
					else
						finish = 1'b1;
				end
			end
			ST_STOP2:
			begin
				if (samp)
				begin
					nxt_q.fr_bad = fr_now;                              // RULE2
					finish = 1'b1;
				end
			end
			ST_BRK:
			begin
				// The low line is still the break, not a new start
				if (rx_line)
					nxt_q.st = ST_IDLE;                                 // RULE9
			end
			default:
				nxt_q.st = ST_IDLE;
		endcase
		// Data words without a frame error are dropped in address mode; a break still lands
		store    = finish && (!addr9 || q_ff.shreg[8] || fr_now);       // RULE11
		is_break = finish && fr_now && !rx_line && (q_ff.shreg == 9'h000); // RULE8
		if (finish)
			nxt_q.st = is_break ? ST_BRK : ST_IDLE;                     // RULE8 RULE9 RULE10
		if (store)
		begin
			nxt_q.rbuf.data = q_ff.shreg;                               // RULE8
			nxt_q.rbuf.frame_error_flag = fr_now;                                   // RULE1 RULE3
			nxt_q.rbuf.parity_error_flag = q_ff.par_bad;                             // RULE5
			ev_set[EV_FRAME_ERROR_FLAG] = fr_now;
			ev_set[EV_PARITY_ERROR_FLAG] = q_ff.par_bad;
			if (addr9)
				ev_set[EV_RX] = q_ff.shreg[8];                          // RULE12
			else
				ev_set[EV_RX] = q_ff.isel ? (fr_now | q_ff.par_bad) : 1'b1;
		end
		// Register writes
		if (req.wr)
		begin
			if (req.addr == OFS_MODE)
			begin
				nxt_q.stop2 = req.wdata[MODE_STOP];
				nxt_q.parity_data_select = req.wdata[MODE_PDLO +: 2];
				nxt_q.lpbk  = req.wdata[MODE_LPBK];
			end
			else if (req.addr == OFS_STAT)
			begin
				nxt_q.address_detect_enable = req.wdata[STAT_ADDRESS_DETECT_ENABLE];
				nxt_q.isel  = req.wdata[STAT_ISEL];
			end
			else if (req.addr == OFS_BRG)
				nxt_q.brg = req.wdata;                                  // RULE15 RULE16
			else if (req.addr == OFS_INTST)
				nxt_q.ev_st = q_ff.ev_st & ~req.wdata[NEV-1:0];
			else if (req.addr == OFS_INTMK)
				nxt_q.ev_mask = req.wdata[NEV-1:0];
		end
		// Reading the data register empties the buffer
		if (req.rd && req.addr == OFS_DATA)
			nxt_q.avail = 1'b0;
		// Hardware sets win over software clears in the same cycle
		if (store)
			nxt_q.avail = 1'b1;                                         // RULE8
		nxt_q.ev_st = nxt_q.ev_st | ev_set;
		// Read data, one cycle after the strobe; unmapped reads zero
		nxt_q.rdata = 16'h0000;
		if (req.rd)
		begin
			if (req.addr == OFS_MODE)
				nxt_q.rdata = {12'h000, q_ff.lpbk, q_ff.parity_data_select, q_ff.stop2};
			else if (req.addr == OFS_STAT)
				nxt_q.rdata = {9'h000, q_ff.isel, q_ff.address_detect_enable, receiver_idle_o,
					q_ff.rbuf.parity_error_flag, q_ff.rbuf.frame_error_flag, 1'b0, q_ff.avail}; // RULE3 RULE5 RULE6
			else if (req.addr == OFS_DATA)
				nxt_q.rdata = {7'h00, q_ff.rbuf.data};
			else if (req.addr == OFS_BRG)
				nxt_q.rdata = q_ff.brg;                                 // RULE15
			else if (req.addr == OFS_INTST)
				nxt_q.rdata = {13'h0000, q_ff.ev_st};
			else if (req.addr == OFS_INTMK)
				nxt_q.rdata = {13'h0000, q_ff.ev_mask};
		end
	end

	// All state, cleared by every reset except the line synchroniser and transmit bit, which idle high
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			q_ff         <= '0;
			q_ff.sync    <= 2'h3;
			q_ff.tx      <= 1'b1;
			q_ff.st      <= ST_IDLE;
			q_ff.brg     <= BRG_RST;
			q_ff.ev_st   <= EV_RST;
			q_ff.ev_mask <= EV_RST;
		end
		else
			q_ff <= nxt_q;
	end

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	property p_frame_error_flag_one_stop;
		(samp && q_ff.st == ST_STOP1 && !q_ff.stop2 && !rx_line && !addr9) |=> (q_ff.rbuf.frame_error_flag && q_ff.avail);
	endproperty
	a_frame_error_flag_one_stop: assert property (p_frame_error_flag_one_stop) else $error("stop low did not set frame error"); // RULE1

	property p_frame_error_flag_two_stop;
		(samp && q_ff.st == ST_STOP1 && q_ff.stop2 && !rx_line) |=> (q_ff.st == ST_STOP2 && q_ff.fr_bad);
	endproperty
	a_frame_error_flag_two_stop: assert property (p_frame_error_flag_two_stop) else $error("first stop low lost"); // RULE2

	property p_flags_reset;
		@(posedge mclk_i) disable iff (1'b0) !rstn_i |=> (!q_ff.rbuf.frame_error_flag && !q_ff.rbuf.parity_error_flag && !q_ff.avail);
	endproperty
	a_flags_reset: assert property (p_flags_reset) else $error("error flags survived reset"); // RULE3

	property p_no_parity;
		(store && (q_ff.parity_data_select == PD_8N || q_ff.parity_data_select == PD_9N)) |=> !q_ff.rbuf.parity_error_flag;
	endproperty
	a_no_parity: assert property (p_no_parity) else $error("parity error without parity mode"); // RULE4

	property p_idle_flag;
		(q_ff.st == ST_IDLE && !rx_line) |=> !receiver_idle_o;
	endproperty
	a_idle_flag: assert property (p_idle_flag) else $error("idle flag wrong while active"); // RULE6

	property p_idle_end;
		finish |=> receiver_idle_o;
	endproperty
	a_idle_end: assert property (p_idle_end) else $error("idle flag not set after stop"); // RULE6

	property p_break_end;
		is_break |=> (q_ff.st == ST_BRK && q_ff.avail && q_ff.rbuf.frame_error_flag && q_ff.rbuf.data == 9'h000);
	endproperty
	a_break_end: assert property (p_break_end) else $error("break not completed"); // RULE8

	property p_break_hold;
		(q_ff.st == ST_BRK && !rx_line) |=> (q_ff.st == ST_BRK && receiver_idle_o);
	endproperty
	a_break_hold: assert property (p_break_hold) else $error("break line taken as start"); // RULE9

	property p_addr_irq;
		(store && addr9 && q_ff.shreg[8]) |=> q_ff.ev_st[EV_RX];
	endproperty
	a_addr_irq: assert property (p_addr_irq) else $error("address word gave no event"); // RULE12

	property p_addr_drop;
		(finish && addr9 && !q_ff.shreg[8] && !fr_now) |-> !store;
	endproperty
	a_addr_drop: assert property (p_addr_drop) else $error("data word kept in address mode"); // RULE11

	property p_loop;
		q_ff.lpbk |-> (rx_line == $past(tx_data_i) && serial_transmit_pin_o == $past(tx_data_i));
	endproperty
	a_loop: assert property (p_loop) else $error("loopback path wrong"); // RULE13

	property p_tick_div1;
		(tick && q_ff.brg == 16'h0001 && !(req.wr && req.addr == OFS_BRG)) |=> !tick ##1 (tick || $changed(q_ff.brg));
	endproperty
	a_tick_div1: assert property (p_tick_div1) else $error("tick spacing wrong for divisor 1"); // RULE15

	property p_tick_div0;
		(q_ff.brg == 16'h0000 && $past(q_ff.brg) == 16'h0000) |-> tick;
	endproperty
	a_tick_div0: assert property (p_tick_div0) else $error("divisor 0 not every clock"); // RULE16

	property p_frame_error_flag_event;
		(store && fr_now) |=> q_ff.ev_st[EV_FRAME_ERROR_FLAG];
	endproperty
	a_frame_error_flag_event: assert property (p_frame_error_flag_event) else $error("frame error gave no event"); // RULE1

	property p_parity_error_flag_event;
		(store && q_ff.par_bad) |=> (q_ff.rbuf.parity_error_flag && q_ff.ev_st[EV_PARITY_ERROR_FLAG]);
	endproperty
	a_parity_error_flag_event: assert property (p_parity_error_flag_event) else $error("parity error not kept"); // RULE4 RULE5

	property p_break_irq;
		is_break |=> q_ff.ev_st[EV_FRAME_ERROR_FLAG];
	endproperty
	a_break_irq: assert property (p_break_irq) else $error("break gave no event"); // RULE8

	property p_break_idle;
		is_break |=> receiver_idle_o;
	endproperty
	a_break_idle: assert property (p_break_idle) else $error("idle low at break"); // RULE10

	property p_start_glitch;
		(q_ff.st == ST_START && tick && q_ff.tcnt == TICK_MID && rx_line) |=> (q_ff.st == ST_IDLE);
	endproperty
	a_start_glitch: assert property (p_start_glitch) else $error("short low taken as start"); // RULE17

	// Timed states advance one count per tick and wrap after sixteen
	property p_bit_time;
		(tick && (q_ff.st == ST_DATA || q_ff.st == ST_PAR || q_ff.st == ST_STOP1 || q_ff.st == ST_STOP2))
			|=> (q_ff.tcnt == $past(q_ff.tcnt) + 4'h1);
	endproperty
	a_bit_time: assert property (p_bit_time) else $error("tick count skipped"); // RULE17

	property p_brg_read;
		(req.rd && req.addr == OFS_BRG) |=> (reg_rdata_o == $past(q_ff.brg));
	endproperty
	a_brg_read: assert property (p_brg_read) else $error("divisor read back wrong"); // RULE15

	c_break: cover property (is_break);
	c_parity_error_flag: cover property (store && q_ff.par_bad);
	c_addr: cover property (store && addr9 && q_ff.shreg[8]);
	c_two_stop: cover property (finish && q_ff.st == ST_STOP2);
	c_loop: cover property (store && q_ff.lpbk);
endmodule : urxs_top

// [dv/urxs_far.sv]
// Far-side serial transmitter model driving one idle-high line.
// Assumes callers run in the mclk_i domain; bit length given in clocks.
module urxs_far (
	input  wire logic mclk_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle level of an asynchronous line is high
	initial line_o = 1'b1;

	// Hold a level for c clocks, changed just after an edge
	task automatic lvl(input logic v, input int c);
		@(posedge mclk_i);
		line_o <= v;
		repeat (c - 1) @(posedge mclk_i);
	endtask : lvl

	// Start bit, then n bits LSB first, then back to idle high
	task automatic send(input logic [10:0] b, input int n, input int bc);
		lvl(1'b0, bc);
		for (int i = 0; i < n; i++) lvl(b[i], bc);
		lvl(1'b1, 1);
	endtask : send
endmodule : urxs_far

// [dv/testbench.sv]
// Self-checking bench for the serial receive status block.
// Assumes the design package and the far-side model are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import urxs_pkg::*;

	logic        mclk_i, rstn_i, ws, rs, idle, irq, rxl, txl, txp;
	logic [2:0]  addr;
	logic [15:0] wd, rdata;
	int          fails = 0, samples_checked = 0, cyc = 0, bc = 16;

	urxs_top i_dut (
		.mclk_i                (mclk_i),
		.rstn_i                (rstn_i),
		.reg_addr_i            (addr),
		.reg_wdata_i           (wd),
		.reg_wr_i              (ws),
		.reg_rd_i              (rs),
		.reg_rdata_o           (rdata),
		.serial_receive_pin_i  (rxl),
		.tx_data_i             (txl),
		.serial_transmit_pin_o (txp),
		.receiver_idle_o       (idle),
		.irq_o                 (irq)
	);
	// Remote sender on the pin, local sender on the transmit path
	urxs_far i_far (.mclk_i(mclk_i), .line_o(rxl));
	urxs_far i_tx (.mclk_i(mclk_i), .line_o(txl));

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	// Hang guard, well above the few thousand cycles needed
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
			$display("BAD %0t got %h expected %h", $time, g, e);
		if (g !== e)
			fails++;
	endtask : chk

	task automatic cb(input logic g, input logic e);
		chk({15'h0, g}, {15'h0, e});
	endtask : cb

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr <= a;
		wd <= d;
		ws <= 1'b1;
		@(posedge mclk_i);
		ws <= 1'b0;
		// Let the write land before any check looks at its effect
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge mclk_i);
		addr <= a;
		rs <= 1'b1;
		@(posedge mclk_i);
		rs <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd

	// Two clocks low, then room for the pin synchroniser
	task automatic rst();
		rstn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask : rst

	// One frame, idle low mid-frame, then status, data, events and irq
	task automatic fr(input logic [15:0] m, input logic [10:0] b, input int n, input logic [15:0] s,
		input logic [15:0] d);
		wr(OFS_MODE, m);
		fork
			i_far.send(b, n, bc);
			begin
				repeat (40) @(posedge mclk_i);
				#1 cb(idle, 1'b0);
			end
		join
		// A low stop may be taken as a start until the half-bit check
		repeat (8) @(posedge mclk_i);
		#1 cb(idle, 1'b1);
		rd(OFS_STAT, s);
		rd(OFS_DATA, d);
		rd(OFS_INTST, {13'h0, s[3], s[2], 1'b1});
		cb(irq, 1'b1);
		wr(OFS_INTST, 16'h0007);
		cb(irq, 1'b0);
	endtask : fr

	initial
	begin
		rstn_i = 1'b0;
		ws = 1'b0;
		rs = 1'b0;
		addr = 3'h0;
		wd = 16'h0000;
		rst();
		for (int a = 0; a < 8; a++) rd(3'(a), (a == 1) ? 16'h0010 : 16'h0000);
		wr(3'h7, 16'hFFFF);
		wr(OFS_STAT, 16'h001F);
		rd(OFS_STAT, 16'h0010);
		rd(3'h7, 16'h0000);
		wr(OFS_INTMK, 16'h0007);
		// Character formats, stop and parity faults
		fr(16'h0000, 11'h7A5, 9, 16'h0011, 16'h00A5);
		fr(16'h0000, 11'h0A5, 9, 16'h0015, 16'h00A5);
		fr(16'h0001, 11'h3A5, 10, 16'h0011, 16'h00A5);
		fr(16'h0001, 11'h1A5, 10, 16'h0015, 16'h00A5);
		fr(16'h0001, 11'h2A5, 10, 16'h0015, 16'h00A5);
		fr(16'h0002, 11'h2A5, 10, 16'h0011, 16'h00A5);
		fr(16'h0002, 11'h3A5, 10, 16'h0019, 16'h00A5);
		fr(16'h0004, 11'h3A5, 10, 16'h0011, 16'h00A5);
		fr(16'h0006, 11'h3A5, 10, 16'h0011, 16'h01A5);
		fr(16'h0007, 11'h7A5, 11, 16'h0011, 16'h01A5);
		// Address detect: data word dropped, address word interrupts
		wr(OFS_STAT, 16'h0060);
		i_far.send(11'h6A5, 11, bc);
		repeat (4) @(posedge mclk_i);
		rd(OFS_STAT, 16'h0070);
		rd(OFS_INTST, 16'h0000);
		fr(16'h0006, 11'h3A5, 10, 16'h0071, 16'h01A5);
		wr(OFS_STAT, 16'h0000);
		wr(OFS_MODE, 16'h0000);
		// Long break, events masked at first
		wr(OFS_INTMK, 16'h0004);
		fork
			i_far.lvl(1'b0, 224);
			begin
				repeat (215) @(posedge mclk_i);
				#1 cb(idle, 1'b1);
			end
		join
		i_far.lvl(1'b1, 32);
		rd(OFS_STAT, 16'h0015);
		rd(OFS_DATA, 16'h0000);
		rd(OFS_INTST, 16'h0003);
		cb(irq, 1'b0);
		wr(OFS_INTMK, 16'h0002);
		cb(irq, 1'b1);
		wr(OFS_INTST, 16'h0003);
		cb(irq, 1'b0);
		wr(OFS_INTMK, 16'h0007);
		fr(16'h0000, 11'h7A5, 9, 16'h0011, 16'h00A5);
		// Loopback: mode first, then loopback, then transmit; pin held low
		wr(OFS_MODE, 16'h0000);
		wr(OFS_MODE, 16'h0008);
		fork
			i_far.lvl(1'b0, 200);
			i_tx.send(11'h73C, 9, bc);
			begin
				repeat (3) @(posedge mclk_i);
				#1 cb(txp, 1'b0);
			end
		join
		i_far.lvl(1'b1, 4);
		rd(OFS_STAT, 16'h0011);
		rd(OFS_DATA, 16'h003C);
		wr(OFS_INTST, 16'h0007);
		wr(OFS_MODE, 16'h0000);
		// Slower rate from divisor 1, then full range and reset
		wr(OFS_BRG, 16'h0001);
		bc = 32;
		fr(16'h0004, 11'h2A5, 10, 16'h0019, 16'h00A5);
		rd(OFS_STAT, 16'h0018);
		wr(OFS_BRG, 16'hFFFF);
		rd(OFS_BRG, 16'hFFFF);
		@(posedge mclk_i);
		rst();
		rd(OFS_STAT, 16'h0010);
		rd(OFS_BRG, 16'h0000);
		final_report();
	end
endmodule : testbench
